/* pkg/btd_defs.vh */
`ifndef BTD_DEFS_VH
`define BTD_DEFS_VH

// ----------------------------------------------------------------
// bundle layout
// ----------------------------------------------------------------
`define BTD_BUNDLE_W 128
`define BTD_BUNDLE_BYTES 16
`define BTD_ALIGN_BITS 4
`define BTD_TMPL_W 5
`define BTD_TMPL_LSB 0
`define BTD_SLOT_W 41
`define BTD_SLOT0_LSB 5
`define BTD_SLOT1_LSB 46
`define BTD_SLOT2_LSB 87

// ----------------------------------------------------------------
// execution unit classes
// ----------------------------------------------------------------
`define BTD_UNIT_W 3
`define BTD_UNIT_M 3'h0
`define BTD_UNIT_I 3'h1
`define BTD_UNIT_F 3'h2
`define BTD_UNIT_B 3'h3
`define BTD_UNIT_L 3'h4
`define BTD_UNIT_X 3'h5
`define BTD_UNIT_NONE 3'h7

// ----------------------------------------------------------------
// immediates
// ----------------------------------------------------------------
`define BTD_IMM_W 64
`define BTD_SIGN_BIT 36
`define BTD_IMM_LSB 13
`define BTD_IMM_FIELD_W 23
`define BTD_LONG_LO_LSB 14
`define BTD_LONG_LO_W 22

// ----------------------------------------------------------------
// decoder states
// ----------------------------------------------------------------
`define BTD_ST_W 2
`define BTD_ST_IDLE 2'h0
`define BTD_ST_ISSUE 2'h1
`define BTD_ST_DRAIN 2'h2

`endif

/* verilog/btd_imm_ext.v */
`include "btd_defs.vh"
`default_nettype none

module btd_imm_ext (
    // slot contents
    input wire [`BTD_SLOT_W-1:0] base_slot,
    input wire [`BTD_SLOT_W-1:0] ext_slot,
    input wire long_form,
    // widened immediate
    output reg [`BTD_IMM_W-1:0] imm
);

    // ----------------------------------------------------------------
    // sign extension
    // ----------------------------------------------------------------
    // the long form draws its sign from the second slot, so the full
    // 64 bits are formed without any extension
    always @* begin
        if (long_form) begin
            imm = {ext_slot[`BTD_SIGN_BIT], base_slot,
                   ext_slot[`BTD_LONG_LO_LSB +: `BTD_LONG_LO_W]};
        end else begin
            imm = {{(`BTD_IMM_W - `BTD_IMM_FIELD_W - 1) // see [RULE_14]
                    {base_slot[`BTD_SIGN_BIT]}},
                   base_slot[`BTD_SIGN_BIT],
                   base_slot[`BTD_IMM_LSB +: `BTD_IMM_FIELD_W]};
        end
    end

endmodule

`default_nettype wire

/* verilog/btd_decoder.v */
// Operation
// [RULE_01] template low five bits, three 41-bit slots
// [RULE_02] bundles sit on 16-byte aligned addresses
// [RULE_03] six instruction types map to unit classes
// [RULE_04] templates 00-03 MII, 04-05 M plus long
// [RULE_05] remaining defined templates route per table
// [RULE_06] reserved templates are never valid combinations
// [RULE_07] template 00 no stops, 03 two stops
// [RULE_08] stop waits for dispatch drain before continuing
// [RULE_09] long instruction spans two slots, issued once
// [RULE_10] bundle bytes assembled little-endian from memory
// [RULE_11] bundles issue in ascending address order
// [RULE_12] slots issue from slot 0 to 2
// [RULE_13] fetch ignores the big-endian data select
// [RULE_14] immediates sign-extended to 64 bits
// [RULE_15] undefined template raises illegal-bundle, issues nothing; if misaligned, only misaligned_bundle is raised
`include "btd_defs.vh"
`default_nettype none

module btd_decoder #(
    parameter ADDR_W = 64
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // fetch side
    input wire fetch_valid,
    output wire fetch_ready,
    input wire [ADDR_W-1:0] fetch_addr,
    input wire [`BTD_BUNDLE_W-1:0] fetch_data,
    // data byte order select, affects loads and stores only
    input wire big_endian_data_select,
    // dispatch side
    output wire issue_valid,
    input wire issue_ready,
    output wire [`BTD_UNIT_W-1:0] issue_unit,
    output wire issue_alu_ok,
    output wire [1:0] issue_slot,
    output wire [`BTD_SLOT_W-1:0] issue_insn,
    output wire [`BTD_SLOT_W-1:0] issue_insn_ext,
    output wire issue_long,
    output wire issue_stop_after,
    output wire [`BTD_IMM_W-1:0] issue_imm,
    output wire [ADDR_W-1:0] issue_addr,
    input wire dispatch_drained,
    // exception side
    output wire illegal_bundle,
    output wire misaligned_bundle,
    output wire [ADDR_W-1:0] fault_addr
);

    // ----------------------------------------------------------------
    // template decode
    // ----------------------------------------------------------------
    // result: {valid, unit0, unit1, unit2}
    function [3*`BTD_UNIT_W:0] tmpl_units;
        input [`BTD_TMPL_W-1:0] t;
        begin
            case (t[4:1])
                4'h0, 4'h1: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_I, `BTD_UNIT_I}; // see [RULE_04]
                4'h2: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_L, `BTD_UNIT_X}; // see [RULE_04]
                4'h4, 4'h5: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_M, `BTD_UNIT_I}; // see [RULE_05]
                4'h6: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_F, `BTD_UNIT_I}; // see [RULE_05]
                4'h7: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_M, `BTD_UNIT_F}; // see [RULE_05]
                4'h8: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_I, `BTD_UNIT_B}; // see [RULE_05]
                4'h9: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_B, `BTD_UNIT_B}; // see [RULE_05]
                4'hB: tmpl_units = {1'b1, `BTD_UNIT_B,
                    `BTD_UNIT_B, `BTD_UNIT_B}; // see [RULE_05]
                4'hC: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_M, `BTD_UNIT_B}; // see [RULE_05]
                4'hE: tmpl_units = {1'b1, `BTD_UNIT_M,
                    `BTD_UNIT_F, `BTD_UNIT_B}; // see [RULE_05]
                default: tmpl_units = {1'b0, `BTD_UNIT_NONE,
                    `BTD_UNIT_NONE, `BTD_UNIT_NONE}; // see [RULE_06]
            endcase
        end
    endfunction

    // stop after slot n, bit n
    function [2:0] tmpl_stops;
        input [`BTD_TMPL_W-1:0] t;
        begin
            tmpl_stops = {t[0], 2'b00}; // see [RULE_07]
            if (t[4:1] == 4'h1) begin
                tmpl_stops[1] = 1'b1; // see [RULE_07]
            end
            if (t[4:1] == 4'h5) begin
                tmpl_stops[0] = 1'b1;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // byte assembly
    // ----------------------------------------------------------------
    // fetch_data carries the lowest-addressed byte in its top lane;
    // the big-endian data select is deliberately not consulted here
    wire [`BTD_BUNDLE_W-1:0] bundle_le;
    genvar g;
    generate
        for (g = 0; g < `BTD_BUNDLE_BYTES; g = g + 1) begin : g_byte
            assign bundle_le[8*g +: 8] = // see [RULE_10]
                fetch_data[`BTD_BUNDLE_W-8-8*g +: 8]; // see [RULE_13]
        end
    endgenerate

    wire [`BTD_TMPL_W-1:0] in_tmpl =
        bundle_le[`BTD_TMPL_LSB +: `BTD_TMPL_W]; // see [RULE_01]
    wire [3*`BTD_UNIT_W:0] in_units = tmpl_units(in_tmpl);
    wire in_legal = in_units[3*`BTD_UNIT_W];
    wire in_aligned =
        (fetch_addr[`BTD_ALIGN_BITS-1:0] == 4'h0); // see [RULE_02]

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam [`BTD_ST_W-1:0] ST_IDLE = `BTD_ST_IDLE;
    localparam [`BTD_ST_W-1:0] ST_ISSUE = `BTD_ST_ISSUE;
    localparam [`BTD_ST_W-1:0] ST_DRAIN = `BTD_ST_DRAIN;
    reg [`BTD_ST_W-1:0] state_reg, state_next;
    reg [`BTD_BUNDLE_W-1:0] bundle_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [1:0] idx_reg, idx_next;
    reg out_valid_reg;
    reg [`BTD_UNIT_W-1:0] out_unit_reg;
    reg [1:0] out_slot_reg;
    reg [`BTD_SLOT_W-1:0] out_insn_reg, out_ext_reg;
    reg out_long_reg, out_stop_reg;
    reg [`BTD_IMM_W-1:0] out_imm_reg;
    reg [ADDR_W-1:0] out_addr_reg;
    reg illegal_reg, misaligned_reg;
    reg [ADDR_W-1:0] fault_addr_reg;

    wire [`BTD_TMPL_W-1:0] cur_tmpl =
        bundle_reg[`BTD_TMPL_LSB +: `BTD_TMPL_W];
    wire [3*`BTD_UNIT_W:0] cur_units = tmpl_units(cur_tmpl);
    wire [2:0] cur_stops = tmpl_stops(cur_tmpl);
    wire [`BTD_SLOT_W-1:0] slot0 = bundle_reg[`BTD_SLOT0_LSB +: `BTD_SLOT_W];
    wire [`BTD_SLOT_W-1:0] slot1 = bundle_reg[`BTD_SLOT1_LSB +: `BTD_SLOT_W];
    wire [`BTD_SLOT_W-1:0] slot2 = bundle_reg[`BTD_SLOT2_LSB +: `BTD_SLOT_W];

    // ----------------------------------------------------------------
    // slot selection
    // ----------------------------------------------------------------
    reg [`BTD_SLOT_W-1:0] sel_insn, sel_ext;
    reg [`BTD_UNIT_W-1:0] sel_unit;
    reg sel_stop, sel_long, sel_last;
    always @* begin
        sel_ext = {`BTD_SLOT_W{1'b0}};
        sel_long = 1'b0;
        case (idx_reg) // see [RULE_12]
            2'h0: begin
                sel_insn = slot0;
                sel_unit = cur_units[2*`BTD_UNIT_W +: `BTD_UNIT_W];
                sel_stop = cur_stops[0];
                sel_last = 1'b0;
            end
            2'h1: begin
                sel_insn = slot1;
                sel_unit = cur_units[`BTD_UNIT_W +: `BTD_UNIT_W];
                sel_stop = cur_stops[1];
                sel_last = 1'b0;
                if (sel_unit == `BTD_UNIT_L) begin
                    // both halves go out as one instruction
                    sel_ext = slot2; // see [RULE_09]
                    sel_long = 1'b1;
                    sel_stop = cur_stops[2];
                    sel_last = 1'b1;
                end
            end
            2'h2: begin
                sel_insn = slot2;
                sel_unit = cur_units[0 +: `BTD_UNIT_W];
                sel_stop = cur_stops[2];
                sel_last = 1'b1;
            end
            default: begin
                sel_insn = {`BTD_SLOT_W{1'b0}};
                sel_unit = `BTD_UNIT_NONE;
                sel_stop = 1'b0;
                sel_last = 1'b1;
            end
        endcase
    end

    wire [`BTD_IMM_W-1:0] sel_imm;
    btd_imm_ext u_imm (
        .base_slot(sel_insn),
        .ext_slot(sel_ext),
        .long_form(sel_long),
        .imm(sel_imm)
    );

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    wire out_free = !out_valid_reg || issue_ready;
    // one bundle at a time keeps lower addresses ahead of higher ones
    assign fetch_ready = (state_reg == ST_IDLE); // see [RULE_11]
    wire accept = fetch_valid && fetch_ready;
    wire take_ok = accept && in_aligned && in_legal;
    wire load_out = (state_reg == ST_ISSUE) && out_free;

    always @* begin
        state_next = state_reg;
        idx_next = idx_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_ok) begin
                    state_next = ST_ISSUE;
                    idx_next = 2'h0;
                end
            end
            ST_ISSUE: begin
                if (out_free) begin
                    idx_next = sel_long ? 2'h3 : idx_reg + 2'h1;
                    if (sel_stop) begin
                        state_next = ST_DRAIN; // see [RULE_08]
                    end else if (sel_last) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_DRAIN: begin
                // earlier work must leave dispatch before later starts
                if (!out_valid_reg && dispatch_drained) begin // see [RULE_08]
                    state_next = (idx_reg == 2'h3) ? ST_IDLE : ST_ISSUE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (state_next == ST_IDLE && state_reg != ST_IDLE) begin
            idx_next = 2'h0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            idx_reg <= 2'h0;
            bundle_reg <= {`BTD_BUNDLE_W{1'b0}};
            addr_reg <= {ADDR_W{1'b0}};
            out_valid_reg <= 1'b0;
            out_unit_reg <= `BTD_UNIT_NONE;
            out_slot_reg <= 2'h0;
            out_insn_reg <= {`BTD_SLOT_W{1'b0}};
            out_ext_reg <= {`BTD_SLOT_W{1'b0}};
            out_long_reg <= 1'b0;
            out_stop_reg <= 1'b0;
            out_imm_reg <= {`BTD_IMM_W{1'b0}};
            out_addr_reg <= {ADDR_W{1'b0}};
            illegal_reg <= 1'b0;
            misaligned_reg <= 1'b0;
            fault_addr_reg <= {ADDR_W{1'b0}};
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            if (take_ok) begin
                bundle_reg <= bundle_le;
                addr_reg <= fetch_addr;
            end
            // a bad bundle is reported and dropped, nothing is issued
            misaligned_reg <= accept && !in_aligned; // see [RULE_02]
            illegal_reg <= accept && in_aligned && !in_legal; // see [RULE_15]
            if (accept && !(in_aligned && in_legal)) begin
                fault_addr_reg <= fetch_addr;
            end
            if (load_out) begin
                out_valid_reg <= 1'b1;
                out_unit_reg <= sel_unit; // see [RULE_03]
                out_slot_reg <= idx_reg;
                out_insn_reg <= sel_insn;
                out_ext_reg <= sel_ext;
                out_long_reg <= sel_long;
                out_stop_reg <= sel_stop;
                out_imm_reg <= sel_imm; // see [RULE_14]
                out_addr_reg <= addr_reg;
            end else if (issue_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign issue_valid = out_valid_reg;
    assign issue_unit = out_unit_reg;
    // integer ALU type may go to either the memory or integer unit
    assign issue_alu_ok = (out_unit_reg == `BTD_UNIT_M) ||
                          (out_unit_reg == `BTD_UNIT_I); // see [RULE_03]
    assign issue_slot = out_slot_reg;
    assign issue_insn = out_insn_reg;
    assign issue_insn_ext = out_ext_reg;
    assign issue_long = out_long_reg;
    assign issue_stop_after = out_stop_reg;
    assign issue_imm = out_imm_reg;
    assign issue_addr = out_addr_reg;
    assign illegal_bundle = illegal_reg;
    assign misaligned_bundle = misaligned_reg;
    assign fault_addr = fault_addr_reg;

endmodule

`default_nettype wire

/* bench/btd_decoder_properties.sv */
`include "btd_defs.vh"
`default_nettype none
module btd_decoder_properties #(
    parameter ADDR_W = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fetch side
    input wire logic fetch_valid,
    input wire logic fetch_ready,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic [127:0] fetch_data,
    // dispatch side
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [2:0] issue_unit,
    input wire logic issue_alu_ok,
    input wire logic [1:0] issue_slot,
    input wire logic [40:0] issue_insn,
    input wire logic [40:0] issue_insn_ext,
    input wire logic issue_long,
    input wire logic issue_stop_after,
    input wire logic [63:0] issue_imm,
    input wire logic dispatch_drained,
    // exception side
    input wire logic illegal_bundle,
    input wire logic misaligned_bundle,
    input wire logic [ADDR_W-1:0] fault_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic take, bad_t, pend_reg;
    logic [4:0] tmpl;
    // lowest-addressed byte arrives in the top lane
    assign tmpl = fetch_data[124:120];
    assign take = fetch_valid && fetch_ready;
    assign bad_t = tmpl inside {5'h06, 5'h07, 5'h14, 5'h15,
        5'h1A, 5'h1B, 5'h1E, 5'h1F};
    // open from a stop's acceptance until dispatch drains
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_reg <= 1'h0;
        end else if (issue_valid && issue_ready && issue_stop_after) begin
            pend_reg <= 1'h1;
        end else if (dispatch_drained) begin
            pend_reg <= 1'h0;
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    bad_tmpl_a:
        assert property (take && fetch_addr[3:0] == 4'h0 && bad_t |=>
            illegal_bundle && fault_addr == $past(fetch_addr))
        else $error("undefined template not flagged");
    misalign_a:
        assert property (take && fetch_addr[3:0] != 4'h0 |=>
            misaligned_bundle && !illegal_bundle)
        else $error("misaligned bundle not flagged");
    stall_hold_a:
        assert property (issue_valid && !issue_ready |=> issue_valid &&
            $stable(issue_insn) && $stable(issue_slot) && $stable(issue_unit))
        else $error("offer changed while stalled");
    stop_wait_a:
        assert property (pend_reg |-> !issue_valid)
        else $error("issue across an undrained stop");
    long_pair_a:
        assert property (issue_valid && issue_long |->
            issue_unit == `BTD_UNIT_L && issue_slot == 2'h1)
        else $error("long instruction misplaced");
    imm_short_a:
        assert property (issue_valid && !issue_long |->
            issue_imm == {{40{issue_insn[36]}}, issue_insn[36:13]})
        else $error("immediate not sign extended");
    imm_long_a:
        assert property (issue_valid && issue_long |-> issue_imm ==
            {issue_insn_ext[36], issue_insn, issue_insn_ext[35:14]})
        else $error("long immediate wrong");
    slot_next_a:
        assert property (issue_valid && issue_ready && !issue_stop_after &&
            issue_slot == 2'h0 |=> issue_valid && issue_slot == 2'h1)
        else $error("slot 1 did not follow slot 0");
    alu_route_a:
        assert property (issue_valid |-> issue_alu_ok ==
            (issue_unit == `BTD_UNIT_M || issue_unit == `BTD_UNIT_I))
        else $error("alu routing flag wrong");
    fetch_refuse_a:
        assert property (take && fetch_addr[3:0] == 4'h0 && !bad_t |=>
            !fetch_ready)
        else $error("fetch still open while a bundle is pending");
endmodule
bind btd_decoder btd_decoder_properties #(.ADDR_W(ADDR_W)) chk (
    .clk, .reset, .fetch_valid, .fetch_ready, .fetch_addr, .fetch_data,
    .issue_valid, .issue_ready, .issue_unit, .issue_alu_ok, .issue_slot,
    .issue_insn, .issue_insn_ext, .issue_long, .issue_stop_after, .issue_imm,
    .dispatch_drained, .illegal_bundle, .misaligned_bundle, .fault_addr
);
`default_nettype wire

/* bench/btd_dispatch_model.sv */
`default_nettype none
module btd_dispatch_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // issue handshake
    input wire logic issue_valid,
    input wire logic issue_stop_after,
    input wire logic stall,
    output logic issue_ready,
    output logic dispatch_drained
);
    timeunit 1ns;
    timeprecision 100ps;
    logic took_stop;
    logic [2:0] busy;
    initial begin
        issue_ready = 1'h1;
        dispatch_drained = 1'h1;
        busy = 3'h0;
    end
    always @(posedge clk) begin
        took_stop <= issue_valid && issue_ready && issue_stop_after;
    end
    // work before a stop needs a few cycles to retire
    always @(negedge clk) begin
        if (reset) begin
            busy = 3'h0;
        end else if (took_stop) begin
            busy = 3'h5;
        end else if (busy != 3'h0) begin
            busy = busy - 3'h1;
        end
        dispatch_drained <= busy == 3'h0;
        // slow mode stalls every other cycle
        issue_ready <= stall ? !issue_ready : 1'h1;
    end
endmodule
`default_nettype wire

/* bench/btd_decoder_bench.sv */
`include "btd_defs.vh"
`default_nettype none
module btd_decoder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0] unit;
        logic [1:0] slot;
        logic lng, stop;
        logic [40:0] insn, ext;
        logic [63:0] imm, addr;
    } btd_rec_t;
    localparam logic [2:0] M = `BTD_UNIT_M, I = `BTD_UNIT_I;
    localparam logic [2:0] F = `BTD_UNIT_F, B = `BTD_UNIT_B;
    localparam logic [8:0] U = 9'h1FF;
    // units per template pair, slot 0 leftmost
    localparam logic [8:0] UNITS [16] = '{{M, I, I}, {M, I, I}, U, U,
        {M, M, I}, {M, M, I}, {M, F, I}, {M, M, F}, {M, I, B}, {M, B, B},
        U, {B, B, B}, {M, M, B}, U, {M, F, B}, U};
    logic clk, reset, fetch_valid, fetch_ready, big_endian_data_select;
    logic issue_valid, issue_ready, issue_alu_ok, issue_long, stall;
    logic issue_stop_after, dispatch_drained, illegal_bundle;
    logic misaligned_bundle;
    logic [1:0] issue_slot;
    logic [2:0] issue_unit;
    logic [40:0] issue_insn, issue_insn_ext;
    logic [63:0] fetch_addr, issue_imm, issue_addr, fault_addr;
    logic [127:0] fetch_data;
    int miscompares, compares, cycles;
    btd_rec_t got_q [$];
    btd_decoder #(.ADDR_W(64)) DUT (.clk, .reset, .fetch_valid,
        .fetch_ready, .fetch_addr, .fetch_data, .big_endian_data_select,
        .issue_valid, .issue_ready, .issue_unit, .issue_alu_ok, .issue_slot,
        .issue_insn, .issue_insn_ext, .issue_long, .issue_stop_after,
        .issue_imm, .issue_addr, .dispatch_drained, .illegal_bundle,
        .misaligned_bundle, .fault_addr);
    btd_dispatch_model PEER (.clk, .reset, .issue_valid, .issue_stop_after,
        .stall, .issue_ready, .dispatch_drained);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (issue_valid && issue_ready) begin
            got_q.push_back('{issue_unit, issue_slot, issue_long,
                issue_stop_after, issue_insn, issue_insn_ext, issue_imm,
                issue_addr});
        end
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [63:0] sx(input logic [40:0] v);
        sx = {{40{v[36]}}, v[36:13]};
    endfunction
    // ----------------
    // fetch handshake
    // ----------------
    // memory order: lowest address in the top byte lane
    task automatic fetch(input logic [63:0] a, input logic [127:0] b);
        fetch_valid = 1'h1;
        fetch_addr = a;
        for (int i = 0; i < 16; i++) begin
            fetch_data[127 - 8 * i -: 8] = b[8 * i +: 8];
        end
        for (int i = 0; i < 100 && fetch_ready !== 1'h1; i++) begin
            @(negedge clk);
        end
        @(negedge clk);
    endtask
    task automatic run_templates(input logic slow);
        logic [40:0] s [3];
        logic [63:0] a;
        logic [8:0] u;
        btd_rec_t e [$];
        btd_rec_t r;
        stall = slow;
        for (int t = 0; t < 32; t++) begin
            for (int k = 0; k < 3; k++) begin
                s[k] = {5'(t + k), 36'h987654321 >> k};
            end
            a = (slow ? 64'h2000 : 64'h1000) + 64'(t * 16);
            u = UNITS[t / 2];
            e.delete();
            if (t / 2 == 2) begin
                e.push_back('{M, 2'h0, 1'h0, 1'h0, s[0], 41'h0, sx(s[0]), a});
                e.push_back('{`BTD_UNIT_L, 2'h1, 1'h1, t[0], s[1], s[2],
                    {s[2][36], s[1], s[2][35:14]}, a});
            end else if (u != U) begin
                for (int k = 0; k < 3; k++) begin
                    e.push_back('{u[8 - 3 * k -: 3], 2'(k), 1'h0,
                        (k == 2 && t[0]) || (k == 1 && t / 2 == 1)
                        || (k == 0 && t / 2 == 5), s[k], 41'h0, sx(s[k]), a});
                end
            end
            big_endian_data_select = t[0];
            fetch(a, {s[2], s[1], s[0], 5'(t)});
            fetch_valid = 1'h0;
            if (e.size() == 0) begin
                check(illegal_bundle, 1'h1);
                check(fault_addr, a);
            end
            for (int i = 0; i < 200 && got_q.size() < e.size(); i++) begin
                @(negedge clk);
            end
            repeat (2) @(negedge clk);
            check(got_q.size(), e.size());
            foreach (e[k]) begin
                r = got_q.size() > 0 ? got_q.pop_front() : '0;
                check(r.addr, e[k].addr);
                check(r, e[k]);
            end
            got_q.delete();
        end
    endtask
    // back-to-back bundles off the 16-byte grid
    task automatic run_misaligned;
        logic [63:0] a;
        for (int k = 1; k < 4; k++) begin
            a = 64'h3000 + 64'(k * 5);
            fetch(a, 128'h6);
            check({misaligned_bundle, illegal_bundle}, 2'h2);
            check(fault_addr, a);
        end
        fetch_valid = 1'h0;
        repeat (4) @(negedge clk);
        check(got_q.size(), 0);
    endtask
    initial begin
        reset = 1'h1;
        fetch_valid = 1'h0;
        fetch_addr = 64'h0;
        fetch_data = 128'h0;
        big_endian_data_select = 1'h0;
        stall = 1'h0;
        repeat (3) @(negedge clk);
        reset = 1'h0;
        run_templates(1'h0);
        run_templates(1'h1);
        run_misaligned();
        print_verdict();
    end
endmodule
`default_nettype wire
